// ---- design/ias_pkg.sv ----
// constants shared by the interrupt acceptance sequencer
package ias_pkg;
  localparam logic [5:0] IEL_OFFSET = 6'h3a;
  localparam int MASTER_BIT = 0;
  localparam logic [7:0] IEL_RESET = 8'h00;
  localparam int PSW_IMF_BIT = 0;
  localparam int PSW_RBS_LSB = 0;
  localparam int RBS_W = 4;
  localparam int SEQ_CYCLES = 12;
  localparam int PUSH_BYTES = 5;
  localparam logic [3:0] CYC_VEC_LD = 4'h6;
  localparam logic [3:0] CYC_LAST = 4'(SEQ_CYCLES - 1);
  localparam logic [15:0] SP_RESET = 16'h0000;
  localparam logic [15:0] ENTRY_BASE = 16'h8000;
  localparam int CODE_FIELD_LSB = 4;
  typedef enum logic [1:0] {
    IAS_IDLE = 2'b00,
    IAS_SAVE = 2'b01,
    IAS_VECT = 2'b11
  } ias_state_e;
endpackage

// ---- design/ias_vec_rom.sv ----
// vector table: entry address and bank control code per source, registered read
`timescale 1ns/100ps
module ias_vec_rom #(
  parameter int NSRC = 8,
  parameter int IDX_W = 3
) (
  input wire logic clk_sys,
  input wire logic [IDX_W-1:0] rd_idx,
  output logic [23:0] rd_data_q
);
  logic [23:0] table_w [NSRC];
  genvar gi;
  generate
    for (gi = 0; gi < NSRC; gi++) begin : g_ent
      // entry in bits 23:8, bank control code in bits 7:0
      assign table_w[gi] = {ias_pkg::ENTRY_BASE | 16'(gi << 8), 4'(gi), 4'h0};
    end
  endgenerate
  always_ff @(posedge clk_sys) begin
    rd_data_q <= table_w[rd_idx];
  end
endmodule

// ---- design/ias_core.sv ----
// interrupt acceptance sequencer: latches, enables, 12-cycle acceptance, return handling
//
// Summary of operation
// R01: pending latch holds until accepted, reset, cleared
// R02: acceptance runs exactly 12 cycles after instruction
// R03: acceptance clears master enable first
// R04: acceptance clears only accepted source latch
// R05: push five bytes, stack pointer minus five
// R06: vector entry address loaded into program counter
// R07: bank code upper nibble added to bank
// R08: nesting counter increments per acceptance
// R09: acceptance starts promptly after latch set
// R10: master enable zero blocks all maskable sources
// R11: per-source enable bit gates its source
// R12: higher priority waits until master re-enabled
// R13: software never sets master and enables together
// R14: software disables master before editing enables
// R15: no read-modify-write on enable register in NMI
// R16: nested service clears own enable first
// R17: only program counter and status word saved
// R18: returns restore previous register bank automatically
// R19: service ends with matching return instruction
// R20: maskable return pops, sp plus five, enables
// R21: non-maskable return restores saved master enable
// R22: pseudo non-maskable sources ignore all enables
// R23: requests sampled in final instruction cycle
// R24: lowest index wins among acceptable requests
`timescale 1ns/100ps
module ias_core #(
  parameter int NSRC = 8,
  parameter int IDX_W = 3,
  parameter int NEST_W = 8
) (
  input wire logic clk_sys,
  input wire logic reset_n,
  input wire logic [NSRC-1:0] irq_set,
  input wire logic latch_clr_wr,
  input wire logic [NSRC-1:0] latch_clr_data,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [5:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic irq_on_instr,
  input wire logic irq_off_instr,
  input wire logic instr_last_cycle,
  input wire logic [15:0] status_word,
  input wire logic [23:0] program_counter,
  input wire logic maskable_return_instr,
  input wire logic nonmaskable_return_instr,
  input wire logic [15:0] popped_status_word,
  output logic [7:0] reg_rdata_q,
  output logic [NSRC-1:0] irq_pending_latch,
  output logic master_irq_enable,
  output logic seq_busy,
  output logic seq_done,
  output logic stk_wr_q,
  output logic [15:0] stk_addr_q,
  output logic [7:0] stk_wdata_q,
  output logic [15:0] stack_pointer,
  output logic pc_load_q,
  output logic [15:0] pc_load_value_q,
  output logic [ias_pkg::RBS_W-1:0] reg_bank_select,
  output logic [NEST_W-1:0] nest_count
);
  ias_pkg::ias_state_e state_q, state_d;
  logic [3:0] cnt_q, cnt_d;
  logic [NSRC-1:0] latch_q, latch_d;
  logic master_q, master_d;
  logic [NSRC-1:1] src_en_q, src_en_d;
  logic [15:0] sp_q, sp_d;
  logic [ias_pkg::RBS_W-1:0] rbs_q, rbs_d;
  logic [NEST_W-1:0] nest_q, nest_d;
  logic [39:0] save_q, save_d;
  logic [IDX_W-1:0] idx_q, idx_d;
  logic [7:0] rdata_d;
  logic stk_wr_d;
  logic [15:0] stk_addr_d;
  logic [7:0] stk_wdata_d;
  logic pc_load_d;
  logic [15:0] pc_val_d;
  logic [NSRC-1:0] acceptable;
  logic any_acc;
  logic [IDX_W-1:0] win_idx;
  logic accept;
  logic [23:0] vec_data;

  ias_vec_rom #(.NSRC(NSRC), .IDX_W(IDX_W)) u_vec_rom (
    .clk_sys(clk_sys),
    .rd_idx(idx_q),
    .rd_data_q(vec_data)
  );

  // source 0 is pseudo non-maskable; others need master and own enable
  always_comb begin
    acceptable = '0;
    acceptable[0] = latch_q[0]; // R22
    for (int i = 1; i < NSRC; i++) begin
      acceptable[i] = latch_q[i] & src_en_q[i] & master_q; // R10 R11 R12
    end
  end

  always_comb begin
    win_idx = '0;
    for (int i = NSRC - 1; i >= 0; i--) begin
      if (acceptable[i]) begin
        win_idx = IDX_W'(i); // R24
      end
    end
  end

  assign any_acc = |acceptable;
  assign accept = (state_q == ias_pkg::IAS_IDLE) && instr_last_cycle && any_acc; // R23 R09

  always_comb begin
    state_d = state_q;
    cnt_d = cnt_q;
    latch_d = latch_q;
    master_d = master_q;
    src_en_d = src_en_q;
    sp_d = sp_q;
    rbs_d = rbs_q;
    nest_d = nest_q;
    save_d = save_q;
    idx_d = idx_q;
    stk_wr_d = 1'b0;
    stk_addr_d = stk_addr_q;
    stk_wdata_d = stk_wdata_q;
    pc_load_d = 1'b0;
    pc_val_d = pc_load_value_q;
    rdata_d = reg_rdata_q;
    if (reg_rd) begin
      rdata_d = (reg_addr == ias_pkg::IEL_OFFSET) ? {src_en_q, master_q} : 8'h00;
    end
    if (reg_wr && reg_addr == ias_pkg::IEL_OFFSET) begin
      master_d = reg_wdata[ias_pkg::MASTER_BIT];
      src_en_d = reg_wdata[NSRC-1:1];
    end
    if (irq_on_instr) begin
      master_d = 1'b1;
    end
    if (irq_off_instr) begin
      master_d = 1'b0;
    end
    if (latch_clr_wr) begin
      latch_d = latch_d & latch_clr_data; // R01
    end
    if (maskable_return_instr || nonmaskable_return_instr) begin
      sp_d = sp_q + 16'(ias_pkg::PUSH_BYTES); // R20
      nest_d = nest_q - NEST_W'(1); // R19
      rbs_d = popped_status_word[8+ias_pkg::PSW_RBS_LSB +: ias_pkg::RBS_W]; // R18
      master_d = maskable_return_instr ? 1'b1 : popped_status_word[ias_pkg::PSW_IMF_BIT]; // R20 R21
    end
    unique case (state_q)
      ias_pkg::IAS_IDLE: begin
        if (accept) begin
          state_d = ias_pkg::IAS_SAVE;
          cnt_d = 4'h0;
          master_d = 1'b0; // R03
          latch_d[win_idx] = 1'b0; // R04
          idx_d = win_idx;
          // saved status word carries the master enable as it was
          save_d = {status_word[15:8], status_word[7:1] & 7'h7f, master_q, program_counter}; // R17
        end
      end
      ias_pkg::IAS_SAVE: begin
        cnt_d = cnt_q + 4'h1;
        if (cnt_q < 4'(ias_pkg::PUSH_BYTES)) begin
          stk_wr_d = 1'b1; // R05
          stk_addr_d = sp_q;
          stk_wdata_d = save_q[39:32];
          save_d = {save_q[31:0], 8'h00};
          sp_d = sp_q - 16'h0001;
        end
        if (cnt_q == ias_pkg::CYC_VEC_LD) begin
          state_d = ias_pkg::IAS_VECT;
          pc_load_d = 1'b1; // R06
          pc_val_d = vec_data[23:8];
          rbs_d = rbs_q + vec_data[ias_pkg::CODE_FIELD_LSB +: ias_pkg::RBS_W]; // R07
          nest_d = nest_q + NEST_W'(1); // R08
        end
      end
      ias_pkg::IAS_VECT: begin
        cnt_d = cnt_q + 4'h1;
        if (cnt_q == ias_pkg::CYC_LAST) begin
          state_d = ias_pkg::IAS_IDLE; // R02
          cnt_d = 4'h0;
        end
      end
      default: begin
        state_d = ias_pkg::IAS_IDLE;
        cnt_d = 4'h0;
      end
    endcase
    latch_d = latch_d | irq_set; // R01
  end

  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      state_q <= ias_pkg::IAS_IDLE;
      cnt_q <= 4'h0;
      latch_q <= '0;
      master_q <= ias_pkg::IEL_RESET[ias_pkg::MASTER_BIT];
      src_en_q <= '0;
      sp_q <= ias_pkg::SP_RESET;
      rbs_q <= '0;
      nest_q <= '0;
      save_q <= '0;
      idx_q <= '0;
      reg_rdata_q <= 8'h00;
      stk_wr_q <= 1'b0;
      stk_addr_q <= 16'h0000;
      stk_wdata_q <= 8'h00;
      pc_load_q <= 1'b0;
      pc_load_value_q <= 16'h0000;
    end else begin
      state_q <= state_d;
      cnt_q <= cnt_d;
      latch_q <= latch_d;
      master_q <= master_d;
      src_en_q <= src_en_d;
      sp_q <= sp_d;
      rbs_q <= rbs_d;
      nest_q <= nest_d;
      save_q <= save_d;
      idx_q <= idx_d;
      reg_rdata_q <= rdata_d;
      stk_wr_q <= stk_wr_d;
      stk_addr_q <= stk_addr_d;
      stk_wdata_q <= stk_wdata_d;
      pc_load_q <= pc_load_d;
      pc_load_value_q <= pc_val_d;
    end
  end

  assign irq_pending_latch = latch_q;
  assign master_irq_enable = master_q;
  assign seq_busy = state_q != ias_pkg::IAS_IDLE;
  assign seq_done = (state_q == ias_pkg::IAS_VECT) && (cnt_q == ias_pkg::CYC_LAST);
  assign stack_pointer = sp_q;
  assign reg_bank_select = rbs_q;
  assign nest_count = nest_q;

  // length of the current busy run, checked when busy drops
  logic [4:0] busy_run_q, busy_run_d;

  always_comb begin
    busy_run_d = seq_busy ? busy_run_q + 5'h01 : 5'h00;
  end

  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      busy_run_q <= 5'h00;
    end else begin
      busy_run_q <= busy_run_d;
    end
  end

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!reset_n);

  a_seq_length: assert property ($fell(seq_busy) |-> busy_run_q == 5'(ias_pkg::SEQ_CYCLES)) // R02
    else $error("acceptance did not last twelve cycles");
  a_master_clear: assert property (accept |=> !master_irq_enable) // R03
    else $error("master enable not cleared on acceptance");
  a_latch_clear: assert property (accept && !irq_set[win_idx] |=> !latch_q[$past(win_idx)]) // R04
    else $error("accepted latch not cleared");
  a_sp_five: assert property (accept && !maskable_return_instr && !nonmaskable_return_instr
    |=> ##6 (sp_q == $past(sp_q, 7) - 16'h0005)) // R05
    else $error("stack pointer not decremented by five");
  a_push_count: assert property (accept |=> !stk_wr_q ##1 stk_wr_q [*5] ##1 !stk_wr_q) // R05
    else $error("push burst is not five bytes");
  a_nest_up: assert property (pc_load_q && !$past(maskable_return_instr)
    && !$past(nonmaskable_return_instr) |-> nest_q == $past(nest_q) + NEST_W'(1)) // R08
    else $error("nesting counter not incremented");
  a_master_gate: assert property (accept && !master_q |-> win_idx == '0) // R10
    else $error("maskable source accepted with master off");
  a_latch_hold: assert property ($rose(latch_q[1]) && !src_en_q[1] && !latch_clr_wr
    |=> latch_q[1]) // R01
    else $error("blocked latch dropped");
  a_maskable_return_instr_master: assert property (maskable_return_instr && !irq_off_instr && !accept
    |=> master_irq_enable) // R20
    else $error("maskable return left master off");
  a_start_prompt: assert property (instr_last_cycle && any_acc && !seq_busy |=> seq_busy) // R09
    else $error("acceptance not started at sampling point");
  c_accept_nmi: cover property (accept && win_idx == '0);
  c_accept_mask: cover property (accept && win_idx != '0);
  c_nested: cover property (seq_done ##[1:40] accept);
endmodule

// ---- bench/ias_cpu_model.sv ----
// pipeline stand-in: instruction boundaries and state captured at acceptance
`timescale 1ns/100ps
module ias_cpu_model (
  input wire logic clk_sys,
  input wire logic reset_n,
  input wire logic seq_busy,
  output logic instr_last_cycle,
  output logic [15:0] status_word,
  output logic [23:0] program_counter
);
  logic [1:0] ph_q = 2'h0;
  initial instr_last_cycle = 1'b0;
  assign status_word = 16'h5a3c;
  assign program_counter = 24'h123456;
  // four-cycle instructions, frozen while acceptance runs
  always @(posedge clk_sys) begin
    if (!reset_n || seq_busy) ph_q <= 2'h0;
    else ph_q <= ph_q + 2'h1;
    instr_last_cycle <= reset_n && !seq_busy && ph_q == 2'h3;
  end
endmodule

// ---- bench/interrupt_acceptance_sequencer_bench.sv ----
// self-checking bench: register access, acceptance, returns
`timescale 1ns/100ps
module interrupt_acceptance_sequencer_bench;
  logic clk_sys = 1'b0, reset_n = 1'b0, latch_clr_wr = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0;
  logic irq_on_instr = 1'b0, irq_off_instr = 1'b0, maskable_return_instr = 1'b0, nonmaskable_return_instr = 1'b0;
  logic instr_last_cycle, seq_busy, seq_done, stk_wr_q, pc_load_q, master_irq_enable;
  logic [7:0] irq_set = 8'h00, latch_clr_data = 8'h00, reg_wdata = 8'h00;
  logic [7:0] reg_rdata_q, stk_wdata_q, irq_pending_latch, nest_count;
  logic [5:0] reg_addr = 6'h00;
  logic [15:0] popped_status_word = 16'h0000, status_word, stk_addr_q, stack_pointer, pc_load_value_q, pcv;
  logic [23:0] program_counter;
  logic [3:0] reg_bank_select;
  logic [23:0] pushq[$];
  logic [23:0] e1[5] = '{24'h00005a, 24'hffff3d, 24'hfffe12, 24'hfffd34, 24'hfffc56};
  int n_fail = 0, n_compared = 0, cyc = 0, nbusy = 0;
  ias_core ias_core_i (.clk_sys, .reset_n, .irq_set, .latch_clr_wr, .latch_clr_data, .reg_wr, .reg_rd,
    .reg_addr, .reg_wdata, .irq_on_instr, .irq_off_instr, .instr_last_cycle, .status_word, .program_counter,
    .maskable_return_instr, .nonmaskable_return_instr, .popped_status_word, .reg_rdata_q, .irq_pending_latch,
    .master_irq_enable, .seq_busy, .seq_done, .stk_wr_q, .stk_addr_q, .stk_wdata_q, .stack_pointer,
    .pc_load_q, .pc_load_value_q, .reg_bank_select, .nest_count);
  ias_cpu_model ias_cpu_model_i (.clk_sys, .reset_n, .seq_busy, .instr_last_cycle, .status_word,
    .program_counter);
  initial forever #12.5 clk_sys = ~clk_sys;
  task automatic report_and_stop();
    $display("compared %0d mismatches %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  // watchdog on the whole run, plus stack and vector capture
  always @(posedge clk_sys) begin
    cyc <= cyc + 1;
    if (seq_busy) nbusy <= nbusy + 1;
    if (stk_wr_q) pushq.push_back({stk_addr_q, stk_wdata_q});
    if (pc_load_q) pcv <= pc_load_value_q;
    if (cyc == 4000) begin
      n_fail++;
      report_and_stop();
    end
  end
  task automatic chk(string what, logic [23:0] exp, logic [23:0] got);
    n_compared++;
    if (got !== exp) begin
      n_fail++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic wr(logic [5:0] a, logic [7:0] d);
    @(posedge clk_sys) {reg_wr, reg_addr, reg_wdata} <= {1'b1, a, d};
    @(posedge clk_sys) reg_wr <= 1'b0;
  endtask
  task automatic rd_chk(logic [5:0] a, logic [7:0] e);
    @(posedge clk_sys) {reg_rd, reg_addr} <= {1'b1, a};
    @(posedge clk_sys) reg_rd <= 1'b0;
    #1 chk("reg read", e, reg_rdata_q);
  endtask
  task automatic raise(logic [7:0] s);
    @(posedge clk_sys) irq_set <= s;
    @(posedge clk_sys) irq_set <= 8'h00;
    repeat (10) @(posedge clk_sys);
    #1;
  endtask
  task automatic ret(logic nmi, logic [15:0] p);
    @(posedge clk_sys) {nonmaskable_return_instr, maskable_return_instr, popped_status_word} <= {nmi, !nmi, p};
    @(posedge clk_sys) {nonmaskable_return_instr, maskable_return_instr} <= 2'b00;
    #1;
  endtask
  task automatic wait_done();
    int k = 0;
    while (seq_done !== 1'b1 && k < 80) begin
      @(posedge clk_sys);
      #1;
      k++;
    end
    chk("acceptance in time", 1'b1, seq_done);
    @(posedge clk_sys);
    #1;
  endtask
  initial begin
    repeat (20) @(posedge clk_sys);
    reset_n <= 1'b1;
    rd_chk(6'h3a, 8'h00);
    chk("stack pointer", 16'h0000, stack_pointer);
    wr(6'h3a, 8'h0a);
    raise(8'h28);
    chk("latch held", 8'h28, irq_pending_latch);
    chk("nest idle", 8'h00, nest_count);
    nbusy = 0;
    pushq.delete();
    @(posedge clk_sys) irq_on_instr <= 1'b1;
    @(posedge clk_sys) irq_on_instr <= 1'b0;
    wait_done();
    chk("busy cycles", 12, nbusy);
    chk("push count", 5, pushq.size());
    for (int i = 0; i < 5; i++) chk("push", e1[i], pushq[i]);
    chk("sp", 16'hfffb, stack_pointer);
    chk("entry", 16'h8300, pcv);
    chk("bank", 4'h3, reg_bank_select);
    chk("nest", 8'h01, nest_count);
    chk("master", 1'b0, master_irq_enable);
    chk("latch", 8'h20, irq_pending_latch);
    $display("test accept done");
    raise(8'h02);
    chk("nest held", 8'h01, nest_count);
    ret(1'b0, 16'h0000);
    chk("master", 1'b1, master_irq_enable);
    chk("bank", 4'h0, reg_bank_select);
    chk("sp", 16'h0000, stack_pointer);
    chk("nest", 8'h00, nest_count);
    wait_done();
    chk("entry", 16'h8100, pcv);
    chk("bank", 4'h1, reg_bank_select);
    chk("latch", 8'h20, irq_pending_latch);
    ret(1'b0, 16'h0000);
    repeat (10) @(posedge clk_sys);
    #1 chk("nest", 8'h00, nest_count);
    $display("test nesting done");
    @(posedge clk_sys) irq_off_instr <= 1'b1;
    @(posedge clk_sys) {irq_off_instr, latch_clr_wr, latch_clr_data} <= {1'b0, 1'b1, 8'hdf};
    @(posedge clk_sys) latch_clr_wr <= 1'b0;
    #1 chk("latch cleared", 8'h00, irq_pending_latch);
    pushq.delete();
    @(posedge clk_sys) irq_set <= 8'h01;
    @(posedge clk_sys) irq_set <= 8'h00;
    wait_done();
    chk("saved low", 24'hffff3c, pushq[1]);
    chk("entry", 16'h8000, pcv);
    ret(1'b1, 16'h0200);
    chk("master", 1'b0, master_irq_enable);
    chk("bank", 4'h2, reg_bank_select);
    chk("nest", 8'h00, nest_count);
    rd_chk(6'h3b, 8'h00);
    rd_chk(6'h3a, 8'h0a);
    $display("test pseudo done");
    report_and_stop();
  end
endmodule
